//--- inc/srab_pkg.sv
// Shared constants, field layouts and carrier types of the read burst engine
package srab_pkg;

  // ----------------------------------------------------------------
  // Widths of the memory organisation
  // ----------------------------------------------------------------
  localparam int DQ_W           = 16;
  localparam int ROW_W          = 12;
  localparam int COL_W          = 8;
  localparam int BA_W           = 2;
  localparam int NBANK          = 4;
  localparam int FIFO_DEPTH_DEF = 16;

  // ----------------------------------------------------------------
  // Address bit positions of the mode word and the command
  // ----------------------------------------------------------------
  localparam int AP_BIT  = 10;
  localparam int BL_LSB  = 0;
  localparam int BT_BIT  = 3;
  localparam int CL_LSB  = 4;
  localparam int OPM_LSB = 7;

  // Burst length codes, latency codes, operating mode
  localparam logic [2:0] BL_1       = 3'h0;
  localparam logic [2:0] BL_2       = 3'h1;
  localparam logic [2:0] BL_4       = 3'h2;
  localparam logic [2:0] BL_8       = 3'h3;
  localparam logic [2:0] BL_PAGE    = 3'h7;
  localparam logic [2:0] CL_2       = 3'h2;
  localparam logic [2:0] CL_3       = 3'h3;
  localparam logic [1:0] OPM_NORMAL = 2'h0;

  // Command codes as {chip select, row strobe, column strobe, write enable}
  localparam logic [3:0] CMD_LMR = 4'h0;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] bl;
    logic       bt;
    logic [2:0] cl;
  } srab_mode_t;

  localparam srab_mode_t MODE_RST = '{bl: BL_1, bt: 1'b0, cl: CL_3};

  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [BA_W-1:0]   ba;
    logic [ROW_W-1:0]  addr;
    logic              dqm;
    logic [DQ_W-1:0]   dq;
  } srab_pins_t;

  localparam srab_pins_t PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                                       we_n: 1'b1, default: '0};

  typedef struct packed {
    logic [BA_W-1:0]  bank;
    logic [COL_W-1:0] base;
    logic [COL_W-1:0] cnt;
    logic             ap;
  } srab_burst_t;

  localparam srab_burst_t BURST_RST = '0;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_BURST = 1'b1
  } srab_state_t;

  // Column mask of the wrap block for a burst length code
  function automatic logic [COL_W-1:0] bl_mask(input logic [2:0] bl);
    case (bl)
      BL_2:    return 8'h01;
      BL_4:    return 8'h03;
      BL_8:    return 8'h07;
      BL_PAGE: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

endpackage

//--- logic/srab_fifo.sv
// Read data FIFO between the word source and the data pins
`timescale 1ns/1ps
module srab_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Filling side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Draining side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("srab_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             next_ready;
  logic             do_wr;
  logic             do_rd;

  assign do_wr       = in_valid_i && in_ready_o;
  assign do_rd       = out_ready_i && out_valid_o;
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];

  // Pointer and fill level; ready is kept as a flop so the port has no gate
  always_comb
  begin
    next_wr_ptr = do_wr ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + AW'(1) : rd_ptr;
    next_count  = count + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    next_ready  = (next_count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
      in_ready_o <= next_ready;
    end
  end

  // Storage has no reset; a word is only read after it was written
  always_ff @(posedge clk_i)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

endmodule

//--- logic/srab_core.sv
// Read burst engine of a four-bank synchronous DRAM: commands, banks, data
`timescale 1ns/1ps
module srab_core #(
  parameter int FIFO_DEPTH = srab_pkg::FIFO_DEPTH_DEF
) (
  // Clock and reset
  input  wire logic                          CLK_I,
  input  wire logic                          NRST_I,
  // Command and address pins
  input  wire logic                          CS_N_I,
  input  wire logic                          RAS_N_I,
  input  wire logic                          CAS_N_I,
  input  wire logic                          WE_N_I,
  input  wire logic [srab_pkg::BA_W-1:0]     BA_I,
  input  wire logic [srab_pkg::ROW_W-1:0]    ADDR_I,
  // Data pins and mask
  input  wire logic                          DQM_I,
  input  wire logic [srab_pkg::DQ_W-1:0]     DQ_I,
  output logic      [srab_pkg::DQ_W-1:0]     DQ_O,
  output logic                               DQ_OE_O,
  // Word request toward the storage
  output logic                               MEM_REQ_O,
  output logic      [srab_pkg::BA_W-1:0]     MEM_BANK_O,
  output logic      [srab_pkg::ROW_W-1:0]    MEM_ROW_O,
  output logic      [srab_pkg::COL_W-1:0]    MEM_COL_O,
  // Read words from the storage
  input  wire logic                          SRC_VALID_I,
  input  wire logic [srab_pkg::DQ_W-1:0]     SRC_DATA_I,
  output logic                               SRC_READY_O,
  // Captured write word
  output logic                               WR_STROBE_O,
  output logic      [srab_pkg::DQ_W-1:0]     WR_DATA_O,
  output logic                               WR_MASK_O,
  // Status
  output logic      [srab_pkg::NBANK-1:0]    BANK_OPEN_O,
  output logic                               UNDERRUN_O,
  output logic                               CMD_ERR_O,
  output logic                               WR_INVALID_O
);

  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("srab_core: FIFO_DEPTH must be at least 2");
  end

  // ----------------------------------------------------------------
  // Pin synchroniser and command decode
  // ----------------------------------------------------------------
  srab_pkg::srab_pins_t pin_meta;
  srab_pkg::srab_pins_t pin_s;

  // Two stages; only the second stage is read by any logic
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pin_meta <= srab_pkg::PINS_IDLE;
      pin_s    <= srab_pkg::PINS_IDLE;
    end
    else
    begin
      pin_meta <= '{cs_n: CS_N_I, ras_n: RAS_N_I, cas_n: CAS_N_I, we_n: WE_N_I,
                    ba: BA_I, addr: ADDR_I, dqm: DQM_I, dq: DQ_I};
      pin_s    <= pin_meta;
    end
  end

  logic [3:0]                 cmd;
  logic                       cmd_lmr;
  logic                       cmd_act;
  logic                       cmd_rd;
  logic                       cmd_wr;
  logic                       cmd_pre;
  logic                       cmd_bst;
  logic                       a10;
  logic [srab_pkg::COL_W-1:0] col_in;

  // Truth table decode; a high select matches no code and acts as inhibit
  assign cmd     = {pin_s.cs_n, pin_s.ras_n, pin_s.cas_n, pin_s.we_n};
  assign cmd_lmr = (cmd == srab_pkg::CMD_LMR);
  assign cmd_act = (cmd == srab_pkg::CMD_ACT);
  assign cmd_rd  = (cmd == srab_pkg::CMD_RD);
  assign cmd_wr  = (cmd == srab_pkg::CMD_WR);
  assign cmd_pre = (cmd == srab_pkg::CMD_PRE);
  assign cmd_bst = (cmd == srab_pkg::CMD_BST);
  assign a10     = pin_s.addr[srab_pkg::AP_BIT];
  assign col_in  = pin_s.addr[srab_pkg::COL_W-1:0];

  // ----------------------------------------------------------------
  // Mode word
  // ----------------------------------------------------------------
  srab_pkg::srab_mode_t       mode;
  srab_pkg::srab_mode_t       next_mode;
  srab_pkg::srab_mode_t       mode_in;
  logic                       mode_bad;
  logic [srab_pkg::COL_W-1:0] mask;
  logic                       full;
  logic [srab_pkg::NBANK-1:0] bank_open;

  assign mode_in = '{bl: pin_s.addr[srab_pkg::BL_LSB +: 3],
                     bt: pin_s.addr[srab_pkg::BT_BIT],
                     cl: pin_s.addr[srab_pkg::CL_LSB +: 3]};

  // Illegal loads keep the old word so a bad load cannot corrupt bursts
  always_comb
  begin
    next_mode = mode;
    mode_bad  = 1'b0;
    if (cmd_lmr)
    begin
      if (pin_s.addr[srab_pkg::OPM_LSB +: 2] == srab_pkg::OPM_NORMAL
          && (mode_in.cl == srab_pkg::CL_2 || mode_in.cl == srab_pkg::CL_3)
          && (mode_in.bl <= srab_pkg::BL_8 || mode_in.bl == srab_pkg::BL_PAGE)
          && !(mode_in.bl == srab_pkg::BL_PAGE && mode_in.bt)
          && bank_open == '0)
      begin
        next_mode = mode_in; // one length for reads and writes
      end
      else
      begin
        mode_bad = 1'b1;
      end
    end
  end

  assign mask = srab_pkg::bl_mask(mode.bl);
  assign full = (mode.bl == srab_pkg::BL_PAGE);

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  srab_pkg::srab_state_t      state;
  srab_pkg::srab_state_t      next_state;
  srab_pkg::srab_burst_t      burst;
  srab_pkg::srab_burst_t      next_burst;
  logic                       beat_now;
  logic [srab_pkg::BA_W-1:0]  beat_bank;
  logic [srab_pkg::COL_W-1:0] beat_col;
  logic                       stop;
  logic                       ap_close;
  logic                       ap_close_new;

  // Column of a beat: wrap inside the burst block, xor for interleave
  function automatic logic [srab_pkg::COL_W-1:0] col_of(
    input logic [srab_pkg::COL_W-1:0] base,
    input logic [srab_pkg::COL_W-1:0] cnt,
    input logic [srab_pkg::COL_W-1:0] m,
    input logic                       bt);
    logic [srab_pkg::COL_W-1:0] low;
    low = bt ? ((base ^ cnt) & m) : ((base + cnt) & m);
    return (base & ~m) | low; // full page mask wraps at the page end
  endfunction

  // A read always restarts the sequence, which gives gapless truncation
  always_comb
  begin
    next_state   = state;
    next_burst   = burst;
    beat_now     = 1'b0;
    beat_bank    = burst.bank;
    beat_col     = col_of(burst.base, burst.cnt, mask, mode.bt);
    ap_close     = 1'b0;
    ap_close_new = 1'b0;
    stop         = cmd_bst || (cmd_pre && (a10 || pin_s.ba == burst.bank));
    if (cmd_rd)
    begin
      beat_now     = 1'b1;
      beat_bank    = pin_s.ba;
      beat_col     = col_of(col_in, '0, mask, mode.bt);
      ap_close     = (state == srab_pkg::ST_BURST) && burst.ap;
      ap_close_new = (mask == '0) && a10;
      next_burst   = '{bank: pin_s.ba, base: col_in, cnt: 8'h01, ap: a10};
      next_state   = (mask == '0) ? srab_pkg::ST_IDLE : srab_pkg::ST_BURST;
    end
    else if (state == srab_pkg::ST_BURST)
    begin
      if (cmd_wr || stop)
      begin
        next_state = srab_pkg::ST_IDLE;
        ap_close   = burst.ap && cmd_wr;
      end
      else
      begin
        beat_now = 1'b1;
        if (!full && burst.cnt == mask)
        begin
          next_state = srab_pkg::ST_IDLE;
          ap_close   = burst.ap; // row closes at burst end
        end
        else
        begin
          next_burst.cnt = burst.cnt + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Bank table
  // ----------------------------------------------------------------
  logic [srab_pkg::NBANK-1:0]                 next_open;
  logic [srab_pkg::NBANK-1:0][srab_pkg::ROW_W-1:0] row_tab;
  logic [srab_pkg::NBANK-1:0][srab_pkg::ROW_W-1:0] next_row;

  // Per bank: open on activate, close on precharge or auto precharge
  for (genvar b = 0; b < srab_pkg::NBANK; b++) begin : g_bank
    logic act_b;
    logic close_b;
    assign act_b   = cmd_act && pin_s.ba == srab_pkg::BA_W'(b);
    assign close_b = (ap_close && burst.bank == srab_pkg::BA_W'(b))
                     || (ap_close_new && pin_s.ba == srab_pkg::BA_W'(b))
                     || (cmd_pre && (a10 || pin_s.ba == srab_pkg::BA_W'(b)));
    assign next_open[b] = act_b ? 1'b1 : (close_b ? 1'b0 : bank_open[b]);
    assign next_row[b]  = act_b ? pin_s.addr : row_tab[b];
  end

  // ----------------------------------------------------------------
  // Latency pipeline and data output
  // ----------------------------------------------------------------
  logic [2:1]                 pv;
  logic [2:1]                 next_pv;
  logic                       dqm_d1;
  logic                       sel;
  logic                       pop;
  logic                       fifo_valid;
  logic [srab_pkg::DQ_W-1:0]  fifo_data;
  logic                       next_oe;
  logic [srab_pkg::DQ_W-1:0]  next_dq;
  logic                       next_err;
  logic                       next_under;
  logic                       next_wrinv;

  // Output stage picks the tap of the programmed latency
  assign sel     = (mode.cl == srab_pkg::CL_2) ? pv[1] : pv[2];
  assign pop     = sel && !cmd_wr;
  assign next_pv = cmd_wr ? 2'h0 : {pv[1], beat_now}; // write kills queued beats

  // Masked beats still pop so later words stay in order
  always_comb
  begin
    next_oe    = pop && !dqm_d1; // mask taken two cycles late
    next_dq    = (pop && fifo_valid) ? fifo_data : DQ_O;
    next_under = UNDERRUN_O || (pop && !fifo_valid);
    next_wrinv = WR_INVALID_O || (cmd_wr && (pv != '0 || DQ_OE_O) && !dqm_d1);
    next_err   = CMD_ERR_O || mode_bad
                 || ((cmd_rd || cmd_wr) && !bank_open[pin_s.ba])
                 || (cmd_act && bank_open[pin_s.ba]);
  end

  // Word source feeds a FIFO; its ready stalls the source when full
  srab_fifo #(
    .WIDTH (srab_pkg::DQ_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .nrst_i      (NRST_I),
    .in_valid_i  (SRC_VALID_I),
    .in_data_i   (SRC_DATA_I),
    .in_ready_o  (SRC_READY_O),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (pop)
  );

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  assign BANK_OPEN_O = bank_open;

  // Every output is a flop; WR_DATA_O and WR_MASK_O follow the data and mask pins every cycle
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      mode         <= srab_pkg::MODE_RST;
      state        <= srab_pkg::ST_IDLE;
      burst        <= srab_pkg::BURST_RST;
      bank_open    <= '0;
      row_tab      <= '0;
      pv           <= '0;
      dqm_d1       <= 1'b0;
      DQ_O         <= '0;
      DQ_OE_O      <= 1'b0;
      MEM_REQ_O    <= 1'b0;
      MEM_BANK_O   <= '0;
      MEM_ROW_O    <= '0;
      MEM_COL_O    <= '0;
      WR_STROBE_O  <= 1'b0;
      WR_DATA_O    <= '0;
      WR_MASK_O    <= 1'b0;
      UNDERRUN_O   <= 1'b0;
      CMD_ERR_O    <= 1'b0;
      WR_INVALID_O <= 1'b0;
    end
    else
    begin
      mode         <= next_mode;
      state        <= next_state;
      burst        <= next_burst;
      bank_open    <= next_open;
      row_tab      <= next_row;
      pv           <= next_pv;
      dqm_d1       <= pin_s.dqm;
      DQ_O         <= next_dq;
      DQ_OE_O      <= next_oe; // idle beats leave the lines released
      MEM_REQ_O    <= beat_now;
      MEM_BANK_O   <= beat_bank;
      MEM_ROW_O    <= row_tab[beat_bank];
      MEM_COL_O    <= beat_col;
      WR_STROBE_O  <= cmd_wr;
      WR_DATA_O    <= pin_s.dq;
      WR_MASK_O    <= pin_s.dqm; // input mask has no delay
      UNDERRUN_O   <= next_under;
      CMD_ERR_O    <= next_err;
      WR_INVALID_O <= next_wrinv;
    end
  end

  // ----------------------------------------------------------------
  // Assertions and cover points
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  AST_OPMODE_RESERVED:
    assert property (cmd_lmr && pin_s.addr[srab_pkg::OPM_LSB +: 2] != srab_pkg::OPM_NORMAL
                     |=> mode == $past(mode) && CMD_ERR_O)
    else $error("reserved operating mode was accepted");

  AST_CL_LEGAL:
    assert property (mode.cl == srab_pkg::CL_2 || mode.cl == srab_pkg::CL_3)
    else $error("latency left the legal set");

  AST_FIRST_DATA_CL2:
    assert property (cmd_rd && mode.cl == srab_pkg::CL_2 ##1 (!cmd_wr && !dqm_d1 && !cmd_lmr)
                     |=> DQ_OE_O)
    else $error("first data missing two cycles after read");

  AST_RELEASE:
    assert property (!$past(sel) |-> !DQ_OE_O)
    else $error("data lines driven without a due beat");

  AST_BLOCK_WRAP:
    assert property (state == srab_pkg::ST_BURST && !full && beat_now && !cmd_rd
                     |-> (beat_col & ~mask) == (burst.base & ~mask))
    else $error("burst left its wrap block");

  AST_PAGE_WRAP:
    assert property (beat_now && full && beat_col == 8'hff ##1 (beat_now && !cmd_rd)
                     |-> beat_col == 8'h00)
    else $error("full page did not wrap to column zero");

  AST_WRITE_HIZ:
    assert property (cmd_wr |=> !DQ_OE_O && pv == '0)
    else $error("data lines driven after a write");

  AST_DQM_MASK:
    assert property (pin_s.dqm |-> ##2 !DQ_OE_O)
    else $error("mask did not suppress output two cycles later");

  AST_AP_CLOSE:
    assert property (ap_close && !(cmd_act && pin_s.ba == burst.bank)
                     |=> !bank_open[$past(burst.bank)])
    else $error("auto precharge left the row open");

  AST_READ_ANY_CYCLE:
    assert property (cmd_rd |=> MEM_REQ_O && MEM_BANK_O == $past(pin_s.ba))
    else $error("back to back read not served");

  AST_TRUNC_STOP:
    assert property (stop && state == srab_pkg::ST_BURST && !cmd_rd
                     |=> !MEM_REQ_O && state == srab_pkg::ST_IDLE)
    else $error("truncation did not stop the burst");

  COV_FULL_PAGE:   cover property (cmd_rd && full);
  COV_READ_TRUNC:  cover property (cmd_rd && state == srab_pkg::ST_BURST);
  COV_WRITE_TRUNC: cover property (cmd_wr && DQ_OE_O);
  COV_AUTO_PRE:    cover property (ap_close);

endmodule

//--- bench/srab_ctrl_model.sv
// Memory controller model driving command, address, mask and write data pins
`timescale 1ns/1ps
module srab_ctrl_model (
  // Clock and pins
  input  wire logic            clk_i,
  output srab_pkg::srab_pins_t pins_o
);
  // Idle pins until the bench asks for a command
  initial pins_o = srab_pkg::PINS_IDLE;
  // One command per call; data flips so a stale bus never looks valid
  task automatic cmd(input logic [3:0] c, input logic [1:0] ba, input logic [11:0] a);
    @(posedge clk_i);
    {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= c;
    pins_o.ba   <= ba;
    pins_o.addr <= a;
    pins_o.dq   <= ~pins_o.dq;
  endtask
  // Mask level, raised well ahead of a truncating write
  task automatic mask(input logic m);
    @(posedge clk_i);
    pins_o.dqm <= m;
  endtask
endmodule

//--- bench/sdram_row_activate_read_burst_bench.sv
// Self-checking bench of the read burst engine
`timescale 1ns/1ps
module sdram_row_activate_read_burst_bench;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic                 clk       = 1'b0;
  logic                 rst_n     = 1'b0;
  logic                 src_valid = 1'b0;
  logic [15:0]          src_data  = 16'h0000;
  logic [15:0]          dq_o;
  logic                 dq_oe;
  logic                 mem_req;
  logic                 wr_mask;
  logic                 wr_strobe;
  logic [15:0]          wr_data;
  logic                 underrun;
  logic                 src_ready;
  logic [1:0]           mem_bank;
  logic [11:0]          mem_row;
  logic                 cmd_err;
  logic                 wr_inv;
  logic [7:0]           mem_col;
  logic [3:0]           bank_open;
  srab_pkg::srab_pins_t pins;
  int                   bad_count   = 0;
  int                   checks_done = 0;
  int                   cycles      = 0;
  // 25 MHz clock
  always #20 clk = ~clk; // below 100 MHz, so latency two is allowed
  srab_ctrl_model u_srab_ctrl_model (.clk_i(clk), .pins_o(pins));
  srab_core u_srab_core (.CLK_I(clk), .NRST_I(rst_n), .CS_N_I(pins.cs_n), .RAS_N_I(pins.ras_n),
    .CAS_N_I(pins.cas_n), .WE_N_I(pins.we_n), .BA_I(pins.ba), .ADDR_I(pins.addr),
    .DQM_I(pins.dqm), .DQ_I(pins.dq), .DQ_O(dq_o), .DQ_OE_O(dq_oe), .MEM_REQ_O(mem_req),
    .MEM_BANK_O(mem_bank), .MEM_ROW_O(mem_row), .MEM_COL_O(mem_col), .SRC_VALID_I(src_valid),
    .SRC_DATA_I(src_data), .SRC_READY_O(src_ready), .WR_STROBE_O(wr_strobe),
    .WR_DATA_O(wr_data), .WR_MASK_O(wr_mask), .BANK_OPEN_O(bank_open),
    .UNDERRUN_O(underrun), .CMD_ERR_O(cmd_err), .WR_INVALID_O(wr_inv));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Four words into the read FIFO; the FIFO has room for all four, so each is taken
  task automatic preload;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      src_valid <= 1'b1;
      src_data  <= 16'ha000 + 16'(i);
    end
    @(posedge clk);
    src_valid <= 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Burst of four from column 2 with auto precharge at a given latency
  task automatic read_burst(input int cl);
    int t;
    preload();
    u_srab_ctrl_model.cmd(srab_pkg::CMD_PRE, 2'h0, 12'h400);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_LMR, 2'h0, {5'h00, 3'(cl), 4'h2});
    u_srab_ctrl_model.cmd(srab_pkg::CMD_ACT, 2'h0, 12'h001);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_RD, 2'h0, 12'h402);
    u_srab_ctrl_model.cmd(4'h7, 2'h0, 12'h000);
    t = 0;
    while (mem_req !== 1'b1 && t < 20)
    begin
      @(negedge clk);
      t++;
    end
    for (t = 0; t < 7; t++)
    begin
      if (t < 4)
        check(mem_col, (8'h02 + 8'(t)) & 8'h03);
      if (t >= cl - 1 && t < cl + 3)
        check({dq_oe, dq_o}, 32'h1a000 + t - cl + 1);
      if (t == cl + 3)
        check(dq_oe, 1'b0);
      @(negedge clk);
    end
    check({src_ready, bank_open[0]}, 2'h2);
  endtask
  // Read cut short by a write after its first beat is due, mask high or low ahead
  task automatic write_cut(input logic m, input logic [1:0] ba, input logic exp_inv);
    preload();
    u_srab_ctrl_model.mask(m);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_ACT, ba, 12'h002);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_RD, ba, 12'h000);
    u_srab_ctrl_model.cmd(4'h7, ba, 12'h000);
    u_srab_ctrl_model.cmd(4'h7, ba, 12'h000);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_WR, ba, 12'h000);
    u_srab_ctrl_model.cmd(4'h7, ba, 12'h000);
    u_srab_ctrl_model.mask(1'b0);
    // Cycle of the write: first beat shows only when the mask was low
    @(negedge clk);
    check(dq_oe, !m);
    // Cycle after the write: captured word, then lines released
    @(negedge clk);
    check({wr_strobe, wr_mask, wr_data}, {1'b1, m, ~pins.dq});
    check({wr_inv, dq_oe}, {exp_inv, 1'b0});
  endtask
  // Mode load with operating mode bits set is refused
  task automatic bad_mode;
    check(cmd_err, 1'b0);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_PRE, 2'h0, 12'h400);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_LMR, 2'h0, 12'h1a2);
    u_srab_ctrl_model.cmd(4'h7, 2'h0, 12'h000);
    repeat (4) @(negedge clk);
    check(cmd_err, 1'b1);
  endtask
  // Full-page read across the page end, cut by terminate, then a read cut by precharge
  task automatic page_cut;
    u_srab_ctrl_model.cmd(srab_pkg::CMD_PRE, 2'h0, 12'h400);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_LMR, 2'h0, 12'h027);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_ACT, 2'h3, 12'h003);
    u_srab_ctrl_model.cmd(4'h7, 2'h3, 12'h000);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_RD, 2'h3, 12'h0fe);
    u_srab_ctrl_model.cmd(4'h7, 2'h3, 12'h000);
    u_srab_ctrl_model.cmd(4'h7, 2'h3, 12'h000);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_BST, 2'h3, 12'h000);
    u_srab_ctrl_model.cmd(4'h7, 2'h3, 12'h000);
    @(negedge clk);
    check({mem_req, mem_bank, mem_row, mem_col}, 23'h7003ff);
    @(negedge clk);
    check({mem_req, mem_bank, mem_row, mem_col}, 23'h700300);
    @(negedge clk);
    check(mem_req, 1'b0);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_RD, 2'h3, 12'h010);
    u_srab_ctrl_model.cmd(srab_pkg::CMD_PRE, 2'h3, 12'h000);
    u_srab_ctrl_model.cmd(4'h7, 2'h3, 12'h000);
    repeat (2) @(negedge clk);
    check({mem_req, mem_bank, mem_row, mem_col}, 23'h700310);
    @(negedge clk);
    check({mem_req, bank_open[3], underrun}, 3'h0);
  endtask
  // ------------------------------------------------------------
  // Main sequence and hang guard
  // ------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    read_burst(2);
    read_burst(3);
    write_cut(1'b1, 2'h1, 1'b0);
    write_cut(1'b0, 2'h2, 1'b1);
    bad_mode();
    page_cut();
    print_verdict();
  end
  // Whole run needs about a hundred and ten cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      print_verdict();
    end
  end
endmodule
